// ==== inc/itic_pkg.sv ====
// Purpose: Shared constants and types for the ingress timestamp insertion block
// Assumes: Management registers are 16 bits wide on a 5-bit register address
// Notes:   Each offset, field position, reset value and count is named once here
package itic_pkg;

  // Register offsets on the management port
  localparam logic [4:0]  ADDR_INS_CTRL = 5'h17;
  localparam logic [4:0]  ADDR_CORR_SEL = 5'h18;

  // Reset values and writable bits
  localparam logic [15:0] INS_CTRL_RST   = 16'h0000;
  localparam logic [15:0] CORR_SEL_RST   = 16'h0000;
  localparam logic [15:0] INS_CTRL_WMASK = 16'hff7f;
  localparam logic [15:0] REG_UNMAPPED   = 16'h0000;

  // Field positions in the insertion control register
  localparam int unsigned SEC_SEL_LSB  = 14;
  localparam int unsigned SECONDS_BYTE_OFFSET_LSB  = 8;
  localparam int unsigned NSEC_EN_BIT  = 6;
  localparam int unsigned SUBSECOND_BYTE_OFFSET_LSB = 0;

  // Seconds write selector codes and their byte counts, plus nanoseconds and emulation record lengths
  localparam logic [1:0] SEC_SEL_ONE  = 2'h1;
  localparam logic [1:0] SEC_SEL_FOUR = 2'h2;
  localparam logic [1:0] SEC_SEL_SIX  = 2'h3;
  localparam logic [3:0] SEC_LEN_ONE  = 4'h1;
  localparam logic [3:0] SEC_LEN_FOUR = 4'h4;
  localparam logic [3:0] SEC_LEN_SIX  = 4'h6;
  localparam logic [3:0] NSEC_LEN     = 4'h4;
  localparam logic [3:0] EMU_LEN      = 4'ha;

  // Header byte that carries the least significant byte of correctionField
  localparam logic [7:0] CF_LSB_POS = 8'h0f;

  // Correction select codes
  localparam logic [1:0] CORR_NONE  = 2'h0;
  localparam logic [1:0] CORR_ONE   = 2'h1;
  localparam logic [1:0] CORR_TWO   = 2'h2;

  // Data path buffering
  localparam int unsigned FIFO_W     = 9;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned FIFO_SLACK = 2;

  // Stream control states
  typedef enum logic [1:0]
  {
    ST_RUN   = 2'b01,
    ST_FLUSH = 2'b10
  } itic_state_e;

endpackage

// ==== verilog/itic_ram.sv ====
// Purpose: Small dual-port memory with a registered read port
// Assumes: One clock; read and write of the same entry never coincide
// Notes:   Array holds no reset; only the read register is reset
`timescale 1ns/10ps
`default_nettype none
module itic_ram
#(
  parameter int unsigned W  = 9,
  parameter int unsigned D  = 32,
  parameter int unsigned AW = 5
)
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [W-1:0]  wrData,
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output var  logic [W-1:0]  rdData
);

  logic [W-1:0] mem [D];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
  end

  // Registered read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData <= '0;
    end
    else if (rdEn)
    begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // itic_ram
`default_nettype wire

// ==== verilog/itic_fifo.sv ====
// Purpose: First-in first-out buffer with valid and ready on both sides
// Assumes: Depth is a power of two
// Notes:   Read data come from the memory read register; almostFull leaves slack
`timescale 1ns/10ps
`default_nettype none
module itic_fifo
  import itic_pkg::*;
#(
  parameter int unsigned W     = FIFO_W,
  parameter int unsigned D     = FIFO_DEPTH,
  parameter int unsigned SLACK = FIFO_SLACK
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wrValid,
  output logic              wrReady,
  input  wire logic [W-1:0] wrData,
  output logic              almostFull,
  output var  logic         rdValid,
  input  wire logic         rdReady,
  output logic [W-1:0]      rdData
);

  localparam int unsigned AW = $clog2(D);

  logic [AW:0]   cnt;
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;

  // Handshake decode
  wire wrFire = wrValid && wrReady;
  wire load   = (cnt != '0) && (!rdValid || rdReady);
  assign wrReady    = (cnt < (AW+1)'(D));
  assign almostFull = (cnt >= (AW+1)'(D - SLACK));

  // Pointers, fill count and output valid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt     <= '0;
      wrPtr   <= '0;
      rdPtr   <= '0;
      rdValid <= 1'b0;
    end
    else
    begin
      cnt     <= cnt + (AW+1)'(wrFire) - (AW+1)'(load);
      wrPtr   <= wrPtr + AW'(wrFire);
      rdPtr   <= rdPtr + AW'(load);
      rdValid <= load || (rdValid && !rdReady);
    end
  end

  itic_ram
  #(
    .W  (W),
    .D  (D),
    .AW (AW)
  )
  uRam
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrFire),
    .wrAddr (wrPtr),
    .wrData (wrData),
    .rdEn   (load),
    .rdAddr (rdPtr),
    .rdData (rdData)
  );

endmodule // itic_fifo
`default_nettype wire

// ==== verilog/itic_insert.sv ====
// Purpose: Ingress PTP timestamp insertion and correctionField adjustment
// Assumes: Stream, timestamps and correction values come from logic on clk
// Notes:   Eight-byte delay line lets the correction sum carry across bytes
`timescale 1ns/10ps
`default_nettype none
module itic_insert
  import itic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic [15:0] regWdata,
  output var  logic [15:0] regRdata,
  input  wire logic        emulationMode,
  input  wire logic        emulationInsertEnable,
  input  wire logic [47:0] tsSeconds,
  input  wire logic [29:0] tsNanosec,
  input  wire logic [29:0] periodicOutputOneNs,
  input  wire logic [31:0] correctionValueOne,
  input  wire logic [31:0] correctionValueTwo,
  input  wire logic [31:0] correctionValueThree,
  input  wire logic [7:0]  inData,
  input  wire logic        inValid,
  input  wire logic        inLast,
  input  wire logic        inHdrStart,
  input  wire logic        inCwStart,
  output var  logic        inReady,
  output logic [7:0]       outData,
  output logic             outLast,
  output logic             outValid,
  input  wire logic        outReady
);

  logic [15:0] insCtrl;
  logic [15:0] corrSel;
  itic_state_e state;
  itic_state_e next_state;
  logic [63:0] dly;
  logic [7:0]  dlyValid;
  logic [7:0]  dlyLast;
  logic [7:0]  hdrCnt;
  logic        hdrSeen;
  logic [7:0]  cwCnt;
  logic        cwSeen;
  logic [3:0]  msgType;
  logic        fifoWrReady;
  logic        fifoAlmostFull;
  logic [8:0]  fifoRdData;

  // Control register fields
  wire [1:0] secondsWriteSelect   = insCtrl[SEC_SEL_LSB +: 2];
  wire [5:0] secondsByteOffset    = insCtrl[SECONDS_BYTE_OFFSET_LSB +: 6];
  wire       subsecondWriteEnable = insCtrl[NSEC_EN_BIT];
  wire [5:0] subsecondByteOffset  = insCtrl[SUBSECOND_BYTE_OFFSET_LSB +: 6];

  // Register decode and read selection
  wire hitIns = (regAddr == ADDR_INS_CTRL);
  wire hitCor = (regAddr == ADDR_CORR_SEL);
  wire [15:0] rdMux = hitIns ? insCtrl : (hitCor ? corrSel : REG_UNMAPPED);

  // Register writes and registered read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      insCtrl  <= INS_CTRL_RST;
      corrSel  <= CORR_SEL_RST;
      regRdata <= REG_UNMAPPED;
    end
    else
    begin
      if (regWrite && hitIns)
      begin
        insCtrl <= regWdata & INS_CTRL_WMASK;
      end
      if (regWrite && hitCor)
      begin
        corrSel <= regWdata;
      end
      regRdata <= rdMux;
    end
  end

  // Byte positions from the header start and the control word start
  wire       inFire  = inValid && inReady;
  wire [7:0] hdrPos  = inHdrStart ? 8'h00 : hdrCnt;
  wire       hdrOk   = inHdrStart || hdrSeen;
  wire [7:0] cwPos   = inCwStart ? 8'h00 : cwCnt;
  wire       cwOk    = inCwStart || cwSeen;

  // Seconds insertion window
  wire [3:0] secLen = (secondsWriteSelect == SEC_SEL_ONE)  ? SEC_LEN_ONE :
                      (secondsWriteSelect == SEC_SEL_FOUR) ? SEC_LEN_FOUR :
                      (secondsWriteSelect == SEC_SEL_SIX)  ? SEC_LEN_SIX : 4'h0;
  wire [7:0] secIdx  = hdrPos - {2'b00, secondsByteOffset};
  wire       secHit  = hdrOk && (hdrPos >= {2'b00, secondsByteOffset})
                       && (secIdx < {4'h0, secLen});
  wire [3:0] secRank = secLen - 4'h1 - secIdx[3:0];
  wire [7:0] secByte = 8'(tsSeconds >> {secRank, 3'b000});

  // Nanoseconds or emulation record window
  wire        nsActive = subsecondWriteEnable
                         && (!emulationMode || emulationInsertEnable);
  wire [79:0] nsField  = emulationMode ?
                         {2'b00, tsNanosec, 2'b00, periodicOutputOneNs,
                          correctionValueOne[15:0]} :
                         {48'h0, 2'b00, tsNanosec};
  wire [3:0]  nsLen    = emulationMode ? EMU_LEN : NSEC_LEN;
  wire [7:0]  nsPos    = emulationMode ? cwPos : hdrPos;
  wire        nsOk     = emulationMode ? cwOk : hdrOk;
  wire [7:0]  nsIdx    = nsPos - {2'b00, subsecondByteOffset};
  wire        nsHit    = nsActive && nsOk && (nsPos >= {2'b00, subsecondByteOffset})
                         && (nsIdx < {4'h0, nsLen});
  wire [3:0]  nsRank   = nsLen - 4'h1 - nsIdx[3:0];
  wire [7:0]  nsByte   = 8'(nsField >> {nsRank, 3'b000});

  // Substituted byte; nanoseconds win where the two windows overlap
  wire [7:0] subByte = nsHit ? nsByte : (secHit ? secByte : inData);

  // Correction selection by message type
  wire [3:0]  typeNow  = (hdrPos == 8'h00) ? inData[3:0] : msgType;
  wire [1:0]  corrCode = corrSel[{typeNow[2:0], 1'b0} +: 2];
  wire [31:0] corrAdd  = (corrCode == CORR_ONE) ? correctionValueOne :
                         (corrCode == CORR_TWO) ? correctionValueTwo :
                         correctionValueThree;
  wire        corrNow  = inFire && hdrOk && (hdrPos == CF_LSB_POS)
                         && !typeNow[3] && (corrCode != CORR_NONE);

  // Delay line shift and the correction sum over the last eight bytes
  wire        flushing = (state == ST_FLUSH);
  wire        advance  = inFire || (flushing && fifoWrReady);
  wire [7:0]  shByte   = inFire ? subByte : 8'h00;
  wire [63:0] shv      = {dly[55:0], shByte};
  wire [63:0] sumv     = shv + {32'h0, corrAdd};
  wire [63:0] nextDly  = corrNow ? sumv : shv;
  wire        fifoPush = advance && dlyValid[7];
  wire        drained  = (dlyValid[6:0] == 7'h00);

  // Stream state: run until the last byte, then drain the delay line
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RUN:
      begin
        if (inFire && inLast)
        begin
          next_state = ST_FLUSH;
        end
      end
      ST_FLUSH:
      begin
        if (advance && drained)
        begin
          next_state = ST_RUN;
        end
      end
      default:
      begin
        next_state = ST_RUN;
      end
    endcase
  end

  // State, input ready and delay line
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_RUN;
      inReady  <= 1'b0;
      dly      <= '0;
      dlyValid <= '0;
      dlyLast  <= '0;
    end
    else
    begin
      state   <= next_state;
      inReady <= (next_state == ST_RUN) && !fifoAlmostFull;
      if (advance)
      begin
        dly      <= nextDly;
        dlyValid <= {dlyValid[6:0], inFire};
        dlyLast  <= {dlyLast[6:0], inFire && inLast};
      end
    end
  end

  // Header and control word position tracking, message type capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hdrCnt  <= '0;
      hdrSeen <= 1'b0;
      cwCnt   <= '0;
      cwSeen  <= 1'b0;
      msgType <= '0;
    end
    else if (inFire)
    begin
      hdrCnt  <= (hdrPos == 8'hff) ? hdrPos : hdrPos + 8'h01;
      cwCnt   <= (cwPos == 8'hff) ? cwPos : cwPos + 8'h01;
      hdrSeen <= hdrOk && !inLast;
      cwSeen  <= cwOk && !inLast;
      if (hdrOk && (hdrPos == 8'h00))
      begin
        msgType <= inData[3:0];
      end
    end
  end

  // Output buffer toward the MAC side
  itic_fifo
  #(
    .W     (FIFO_W),
    .D     (FIFO_DEPTH),
    .SLACK (FIFO_SLACK)
  )
  uFifo
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .wrValid    (fifoPush),
    .wrReady    (fifoWrReady),
    .wrData     ({dlyLast[7], dly[63:56]}),
    .almostFull (fifoAlmostFull),
    .rdValid    (outValid),
    .rdReady    (outReady),
    .rdData     (fifoRdData)
  );

  // Buffer entry split into byte and end marker
  assign outData = fifoRdData[7:0];
  assign outLast = fifoRdData[8];

endmodule // itic_insert
`default_nettype wire

// ==== tb/itic_insert_chk.sv ====
// Purpose: Port assertions for itic_insert
// Assumes: The PTP header starts at packet byte 0
// Notes:   A shadow of the control register locates the written bytes
`timescale 1ns/10ps
`default_nettype none
module itic_insert_chk
  import itic_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [4:0]  regAddr,
  input wire logic        regWrite,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        emulationMode,
  input wire logic [47:0] tsSeconds,
  input wire logic [29:0] tsNanosec,
  input wire logic        inValid,
  input wire logic        inLast,
  input wire logic        inReady,
  input wire logic [7:0]  outData,
  input wire logic        outLast,
  input wire logic        outValid,
  input wire logic        outReady
);
  logic [15:0] shCtrl;
  logic [6:0]  pos;
  logic        wrSeen;
  // Byte windows of the seconds and nanoseconds fields
  wire         take = outValid && outReady;
  wire [1:0]   sSel = shCtrl[15:14];
  wire [3:0]   sLen = (sSel == SEC_SEL_ONE) ? SEC_LEN_ONE : (sSel == SEC_SEL_FOUR) ? SEC_LEN_FOUR : SEC_LEN_SIX;
  wire [6:0]   sIdx = pos - {1'b0, shCtrl[13:8]};
  wire [6:0]   nIdx = pos - {1'b0, shCtrl[5:0]};
  wire         sWin = sSel != 2'h0 && pos >= {1'b0, shCtrl[13:8]} && sIdx < {3'h0, sLen};
  wire         nWin = shCtrl[6] && !emulationMode && pos >= {1'b0, shCtrl[5:0]} && nIdx < 7'h04;
  wire [47:0]  sVal = tsSeconds >> (8 * (sLen - 4'h1 - sIdx[3:0]));
  wire [31:0]  nVal = {2'b00, tsNanosec} >> (8 * (7'h03 - nIdx));
  // Shadow the control register and count bytes leaving in a packet
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shCtrl <= 16'h0000;
      wrSeen <= 1'b0;
      pos    <= 7'h00;
    end
    else
    begin
      if (regWrite)
        wrSeen <= 1'b1;
      if (regWrite && regAddr == ADDR_INS_CTRL)
        shCtrl <= regWdata & INS_CTRL_WMASK;
      if (take)
        pos <= outLast ? 7'h00 : pos + 7'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_resv_bit_zero:
    assert property ($past(regAddr) == ADDR_INS_CTRL |-> !regRdata[7]) else $error("reserved bit set");
  a_ctrl_readback:
    assert property (regWrite && regAddr == ADDR_INS_CTRL ##1 !regWrite && regAddr == ADDR_INS_CTRL
      |=> regRdata == ($past(regWdata, 2) & INS_CTRL_WMASK)) else $error("control readback");
  a_corr_readback:
    assert property (regWrite && regAddr == ADDR_CORR_SEL ##1 !regWrite && regAddr == ADDR_CORR_SEL
      |=> regRdata == $past(regWdata, 2)) else $error("select readback");
  a_reset_zero:
    assert property (!wrSeen && ($past(regAddr) == ADDR_INS_CTRL || $past(regAddr) == ADDR_CORR_SEL)
      |-> regRdata == 16'h0000) else $error("register not cleared");
  a_sec_bytes:
    assert property (take && sWin && !nWin |-> outData == sVal[7:0]) else $error("seconds byte");
  a_nsec_bytes:
    assert property (take && nWin |-> outData == nVal[7:0]) else $error("nanoseconds byte");
  a_drain_gap:
    assert property (inValid && inReady && inLast |=> !inReady [*8]) else $error("drain gap short");
  a_out_hold:
    assert property (outValid && !outReady |=> outValid && $stable(outData) && $stable(outLast))
      else $error("output dropped");
  c_sec_write: cover property (take && sWin);
  c_nsec_write: cover property (take && nWin);
  c_in_hold: cover property (inValid && !inReady);
endmodule // itic_insert_chk
bind itic_insert itic_insert_chk chk (.*);
`default_nettype wire

// ==== tb/itic_mac_model.sv ====
// Purpose: MAC side sink for the modified packets
// Assumes: A byte leaves on outValid and outReady
// Notes:   Ready is random unless stall holds it low
`timescale 1ns/10ps
`default_nettype none
module itic_mac_model
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] outData,
  input  wire logic       outLast,
  input  wire logic       outValid,
  input  wire logic       stall,
  output logic            outReady
);
  logic [7:0] rxQ [$];
  int         rxPkts = 0;
  int         seed = 16;
  // Random ready, changed off the sampling edge, low in reset
  always @(negedge clk)
    outReady <= rst_n && !stall && ($random(seed) % 4 != 0);
  // Store each byte taken
  always @(posedge clk)
    if (rst_n && outValid && outReady)
    begin
      rxQ.push_back(outData);
      rxPkts += outLast;
    end
endmodule // itic_mac_model
`default_nettype wire

// ==== tb/itic_insert_tb.sv ====
// Purpose: Self-checking bench for itic_insert
// Assumes: PTP header opens each packet; the control word starts at packet byte 4
// Notes:   A byte model predicts every packet; the sink stalls
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) \
    begin \
      errCount++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module itic_insert_tb
  import itic_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic        regWrite = 1'b0;
  logic [15:0] regWdata = 16'h0000;
  logic        emulationMode = 1'b0;
  logic        emulationInsertEnable = 1'b0;
  logic [47:0] tsSeconds = 48'h0;
  logic [29:0] tsNanosec = 30'h0;
  logic [29:0] periodicOutputOneNs = 30'h0;
  logic [31:0] correctionValueOne = 32'h0;
  logic [31:0] correctionValueTwo = 32'h0;
  logic [31:0] correctionValueThree = 32'h0;
  logic [7:0]  inData = 8'h00;
  logic        inValid = 1'b0;
  logic        inLast = 1'b0;
  logic        inHdrStart = 1'b0;
  logic        inCwStart = 1'b0;
  logic        stall = 1'b0;
  logic [15:0] regRdata;
  logic        inReady;
  logic [7:0]  outData;
  logic        outLast;
  logic        outValid;
  logic        outReady;
  logic [7:0]  pkt [48];
  logic [7:0]  expd [48];
  logic [15:0] ctrl;
  logic [15:0] corrSel;
  logic [15:0] v;
  logic [7:0]  b;
  logic        sawHold;
  int          seed = 16;
  int          errCount = 0;
  int          comparisons = 0;
  int          n;
  itic_insert dut (.*);
  itic_mac_model mac (.*);
  // Clock of 100 ns period
  always #50 clk = ~clk;
  task automatic endOfTest();
    if (errCount == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang();
    errCount++;
    endOfTest();
  endtask
  task automatic regWr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWrite = 1'b1;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask
  task automatic regRd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    d = regRdata;
  endtask
  // Offer one packet, holding each byte until it is taken
  task automatic sendPkt();
    for (int i = 0; i < 48; i++)
    begin
      @(negedge clk);
      inValid = 1'b1;
      inData = pkt[i];
      inHdrStart = (i == 0);
      inCwStart = (i == 4);
      inLast = (i == 47);
      n = 0;
      while (inReady !== 1'b1)
      begin
        sawHold = 1'b1;
        @(negedge clk);
        n++;
        if (n > 500)
          hang();
      end
    end
    @(negedge clk);
    inValid = 1'b0;
    inLast = 1'b0;
  endtask
  // Byte model: correction add, then seconds, then nanoseconds or record
  task automatic buildExp();
    logic [63:0] cf;
    logic [79:0] t;
    logic [1:0]  code;
    int          k;
    expd = pkt;
    code = (pkt[0][3:0] < 4'h8) ? corrSel[2 * pkt[0][2:0] +: 2] : 2'h0;
    for (int i = 8; i < 16; i++)
      cf = {cf[55:0], pkt[i]};
    cf = cf + ((code == 2'h1) ? correctionValueOne : (code == 2'h2) ? correctionValueTwo
      : (code == 2'h3) ? correctionValueThree : 32'h0);
    for (int i = 15; i >= 8; i--)
    begin
      expd[i] = cf[7:0];
      cf = cf >> 8;
    end
    k = (ctrl[15:14] == 2'h1) ? 1 : (ctrl[15:14] == 2'h2) ? 4 : (ctrl[15:14] == 2'h3) ? 6 : 0;
    for (int i = 0; i < k; i++)
    begin
      t = {32'h0, tsSeconds} >> (8 * (k - 1 - i));
      expd[34 + i] = t[7:0];
    end
    k = !ctrl[6] ? 0 : !emulationMode ? 4 : emulationInsertEnable ? 10 : 0;
    for (int i = 0; i < k; i++)
    begin
      t = {2'b00, tsNanosec, 2'b00, periodicOutputOneNs, correctionValueOne[15:0]} >> (8 * (9 - i));
      expd[(emulationMode ? 24 : 20) + i] = t[7:0];
    end
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    regRd(ADDR_INS_CTRL, v);
    `CHK("ctrlReset", 16'h0000, v)
    regRd(ADDR_CORR_SEL, v);
    `CHK("selReset", 16'h0000, v)
    regWr(5'h19, 16'hffff);
    regRd(5'h19, v);
    `CHK("unmapped", REG_UNMAPPED, v)
    for (int p = 0; p < 12; p++)
    begin
      ctrl = {p[1:0], 6'h22, 1'b1, p % 3 != 2, 6'h14};
      corrSel = 16'($random(seed));
      regWr(ADDR_INS_CTRL, ctrl);
      regRd(ADDR_INS_CTRL, v);
      `CHK("ctrl", ctrl & 16'hff7f, v)
      regWr(ADDR_CORR_SEL, corrSel);
      regRd(ADDR_CORR_SEL, v);
      `CHK("corrSel", corrSel, v)
      @(negedge clk);
      emulationMode = (p >= 6);
      emulationInsertEnable = p[0];
      tsSeconds = {16'($random(seed)), 32'($random(seed))};
      tsNanosec = 30'($random(seed));
      periodicOutputOneNs = 30'($random(seed));
      correctionValueOne = $random(seed);
      correctionValueTwo = $random(seed);
      correctionValueThree = $random(seed);
      for (int i = 0; i < 48; i++)
        pkt[i] = 8'($random(seed));
      pkt[0] = {pkt[0][7:4], p[3:0]};
      buildExp();
      sawHold = 1'b0;
      stall = (p == 3);
      if (p == 3)
        fork
          begin
            repeat (100) @(negedge clk);
            stall = 1'b0;
          end
        join_none
      sendPkt();
      if (p == 3)
        `CHK("fullHold", 1'b1, sawHold)
      n = 0;
      while (mac.rxQ.size() < 48)
      begin
        @(negedge clk);
        n++;
        if (n > 2000)
          hang();
      end
      for (int i = 0; i < 48; i++)
      begin
        b = mac.rxQ.pop_front();
        `CHK("outByte", expd[i], b)
      end
      `CHK("packets", p + 1, mac.rxPkts)
    end
    endOfTest();
  end
endmodule // itic_insert_tb
`default_nettype wire
